// ==== rtl/adcc_pkg.sv ====
// Package: shared constants and types for the calibration and parity control link
package adcc_pkg;
  localparam int DATA_W   = 24;
  localparam int FS_W     = 10;
  localparam int MODE_W   = 3;
  localparam int STAT_W   = 8;
  localparam int CHAN_W   = 4;
  // Status byte fields
  localparam int STAT_RDYN_POS   = 7;
  localparam int STAT_PARITY_POS = 4;
  // Operating mode codes, configurable
  localparam logic [2:0] MODE_CONT     = 3'h0;
  localparam logic [2:0] MODE_IDLE     = 3'h2;
  localparam logic [2:0] MODE_PWRDN    = 3'h3;
  localparam logic [2:0] MODE_INT_ZERO = 3'h4;
  localparam logic [2:0] MODE_INT_FULL = 3'h5;
  localparam logic [2:0] MODE_SYS_ZERO = 3'h6;
  localparam logic [2:0] MODE_SYS_FULL = 3'h7;
  // Reset values, then temperature code constants
  localparam logic [23:0] OFFSET_RST = 24'h800000;
  localparam logic [23:0] GAIN_RST   = 24'h400000;
  localparam logic [9:0]  FS_RST     = 10'h060;
  localparam logic [23:0] TEMP_ZERO_K = 24'h800000;
  localparam int          TEMP_CODES_PER_K = 2815;
  // Full-scale coefficient unity is 2^22
  localparam int GAIN_FRAC = 22;
  // Output data period in clk_sys cycles per unit of the filter rate word
  localparam int PERIOD_PER_FS = 1024;
  localparam int SETTLE_SINC4  = 4;
  localparam int SETTLE_FILTER_TYPE_SELECT_BIT  = 3;
  localparam int SETTLE_CHOP   = 2;
  typedef enum logic [1:0] {ADCC_CAL_NONE, ADCC_CAL_OFFSET, ADCC_CAL_GAIN} adcc_cal_type;
endpackage

// ==== rtl/adcc_if.sv ====
// Interface: control and data link between host and converter control
`timescale 1ns/1ps
interface adcc_if;
  import adcc_pkg::*;
  logic [2:0]  op_mode;
  logic        op_mode_wr;
  logic [9:0]  filter_rate_word;
  logic        filter_type_select_bit;
  logic        chop_enable;
  logic        zero_latency;
  logic        parity_enable_bit;
  logic        status_append_bit;
  logic        temp_sensor_select_bit;
  logic        gain_gt1;
  logic        cs_n;
  logic        coef_wr;
  logic        coef_sel_gain;
  logic [23:0] coef_wdata;
  logic [23:0] offset_coef;
  logic [23:0] gain_coef;
  logic        dout_rdy;
  logic        rdy_n;
  logic [23:0] data_word;
  logic [7:0]  status_byte;
  logic        data_rd;
  modport dev (input op_mode, op_mode_wr, filter_rate_word, filter_type_select_bit,
    chop_enable, zero_latency, parity_enable_bit, status_append_bit,
    temp_sensor_select_bit, gain_gt1, cs_n, coef_wr, coef_sel_gain, coef_wdata, data_rd,
    output offset_coef, gain_coef, dout_rdy, rdy_n, data_word, status_byte);
  modport host (output op_mode, op_mode_wr, filter_rate_word, filter_type_select_bit,
    chop_enable, zero_latency, parity_enable_bit, status_append_bit,
    temp_sensor_select_bit, gain_gt1, cs_n, coef_wr, coef_sel_gain, coef_wdata, data_rd,
    input offset_coef, gain_coef, dout_rdy, rdy_n, data_word, status_byte);
endinterface

// ==== rtl/adcc_device.sv ====
// Device end: calibration sequencing, result scaling, parity and status
// Summary of operation
// - Parity generated only when parity enable set
// - Host sets status append with parity
// - Parity bit makes data plus parity even
// - Host flags odd one count as corrupt
// - Temperature select routes sensor to input
// - Bipolar temperature code midscale at zero kelvin
// - Four calibrations chosen by mode field
// - Subtract offset, then multiply by gain
// - Calibration start drives ready high
// - Completion updates coefficient, ready low, idle
// - Internal cal connects source; system needs external
// - Host runs zero before full scale
// - Zero cal, chop off: one settling time
// - Zero cal, chop on: two periods
// - Internal full: one or two settlings
// - System full cal: one settling time
// - Coefficients readable; written only idle or power-down
// - Filter_type_select_bit/sinc4, chop, zero latency options
// - Reset default sinc4 with chop off
// - Filter type bit one selects filter_type_select_bit
// - Host keeps rate word 1 to 1023
// - Status low nibble gives channel
`timescale 1ns/1ps
module adcc_device
  import adcc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  adcc_if.dev              bus,
  input  wire logic        mod_valid,
  input  wire logic [23:0] mod_result,
  input  wire logic [3:0]  mod_channel,
  output logic             temp_route,
  output logic             int_zero_connect,
  output logic             int_full_connect,
  output logic             filter_filter_type_select_bit,
  output logic             filter_chop,
  output logic             filter_zero_latency,
  output logic [2:0]       mode_state
);
  typedef enum {ADCC_S_CONV, ADCC_S_IDLE, ADCC_S_CAL} adcc_state_type;
  adcc_state_type state_reg;
  adcc_state_type state_next;
  logic [2:0]  mode_reg;
  logic [23:0] offset_reg;
  logic [23:0] gain_reg;
  logic [23:0] data_reg;
  logic [7:0]  status_reg;
  logic        rdy_n_reg;
  logic        filter_type_select_bit_reg;
  logic        chop_reg;
  logic        zl_reg;
  // Wide enough for the longest doubled run at the top rate word
  logic [31:0] cal_cnt_reg;

  // Fixed point scaling: (x - offset) * gain / 2^22 + midscale, saturated
  function automatic logic [23:0] scale(input logic [23:0] raw, input logic [23:0] off,
                                        input logic [23:0] gn);
    logic signed [25:0] diff;
    logic signed [50:0] prod;
    logic signed [50:0] res;
    diff = $signed({2'b00, raw}) - $signed({2'b00, off}) + 26'sh0800000;
    prod = 51'(diff - 26'sh0800000) * $signed({27'h0, gn});
    res  = (prod >>> GAIN_FRAC) + 51'sh800000;
    if (res < 0)
      scale = 24'h000000;
    else if (res > 51'shFFFFFF)
      scale = 24'hFFFFFF;
    else
      scale = res[23:0];
  endfunction

  wire         is_cal_code  = bus.op_mode[2];
  wire         cal_start    = bus.op_mode_wr && is_cal_code && state_reg != ADCC_S_CAL;
  wire         coef_wr_ok   = bus.coef_wr && (mode_reg == MODE_IDLE || mode_reg == MODE_PWRDN)
                              && state_reg != ADCC_S_CAL;
  wire [31:0]  period_cyc   = 32'(bus.filter_rate_word) * 32'(PERIOD_PER_FS);
  wire [31:0]  settle_mult  = chop_reg ? 32'(SETTLE_CHOP) :
                              (filter_type_select_bit_reg ? 32'(SETTLE_FILTER_TYPE_SELECT_BIT) : 32'(SETTLE_SINC4));
  wire         full_int     = bus.op_mode == MODE_INT_FULL;
  wire [31:0]  settle_cyc   = period_cyc * settle_mult;
  wire [31:0]  cal_len      = (full_int && bus.gain_gt1) ? settle_cyc * 32'd2 : settle_cyc;
  wire         cal_done     = state_reg == ADCC_S_CAL && cal_cnt_reg == 32'd1 && mod_valid;
  wire         parity_bit   = bus.parity_enable_bit & ^data_reg;

  assign temp_route          = bus.temp_sensor_select_bit;
  assign int_zero_connect    = state_reg == ADCC_S_CAL && mode_reg == MODE_INT_ZERO;
  assign int_full_connect    = state_reg == ADCC_S_CAL && mode_reg == MODE_INT_FULL;
  assign filter_filter_type_select_bit        = filter_type_select_bit_reg;
  assign filter_chop         = chop_reg;
  assign filter_zero_latency = zl_reg;
  assign mode_state          = mode_reg;
  assign bus.offset_coef     = offset_reg;
  assign bus.gain_coef       = gain_reg;
  assign bus.rdy_n           = rdy_n_reg;
  assign bus.dout_rdy        = bus.cs_n ? 1'b1 : rdy_n_reg;
  assign bus.data_word       = data_reg;
  assign bus.status_byte     = {rdy_n_reg, 2'b00, parity_bit, status_reg[3:0]};

  // Mode writes while calibrating are dropped until completion
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ADCC_S_CONV: if (cal_start) state_next = ADCC_S_CAL;
        else if (bus.op_mode_wr && bus.op_mode != MODE_CONT) state_next = ADCC_S_IDLE;
      ADCC_S_IDLE: if (cal_start) state_next = ADCC_S_CAL;
        else if (bus.op_mode_wr && bus.op_mode == MODE_CONT) state_next = ADCC_S_CONV;
      ADCC_S_CAL:  if (cal_done) state_next = ADCC_S_IDLE;
      default:     state_next = ADCC_S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= ADCC_S_CONV;
      mode_reg  <= MODE_CONT;
      filter_type_select_bit_reg <= 1'b0;
      chop_reg  <= 1'b0;
      zl_reg    <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      filter_type_select_bit_reg <= bus.filter_type_select_bit;
      chop_reg  <= bus.chop_enable;
      zl_reg    <= bus.zero_latency;
      if (cal_done)
        mode_reg <= MODE_IDLE;
      else if (bus.op_mode_wr && state_reg != ADCC_S_CAL)
        mode_reg <= bus.op_mode;
    end
  end

  // Calibration timer counts settling cycles, then waits for the filter's next result
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      cal_cnt_reg <= 32'd0;
    end
    else if (cal_start)
      cal_cnt_reg <= (cal_len == 32'd0) ? 32'd1 : cal_len;
    else if (state_reg == ADCC_S_CAL)
    begin
      // Parks at one so a late filter result still ends the run
      if (cal_cnt_reg > 32'd1)
        cal_cnt_reg <= cal_cnt_reg - 32'd1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      offset_reg <= OFFSET_RST;
      gain_reg   <= GAIN_RST;
      data_reg   <= 24'h000000;
      status_reg <= 8'h00;
      rdy_n_reg  <= 1'b1;
    end
    else
    begin
      // A fresh result wins over a read in the same cycle
      if (cal_start)
        rdy_n_reg <= 1'b1;
      else if (cal_done)
        rdy_n_reg <= 1'b0;
      else if (state_reg == ADCC_S_CONV && mod_valid)
        rdy_n_reg <= 1'b0;
      else if (bus.data_rd)
        rdy_n_reg <= 1'b1;
      if (cal_done && (mode_reg == MODE_INT_ZERO || mode_reg == MODE_SYS_ZERO))
        offset_reg <= mod_result;
      else if (coef_wr_ok && !bus.coef_sel_gain)
        offset_reg <= bus.coef_wdata;
      // Full-scale coefficient chosen so the calibrated level maps to full code
      if (cal_done && (mode_reg == MODE_INT_FULL || mode_reg == MODE_SYS_FULL))
        gain_reg <= gain_from(mod_result, offset_reg);
      else if (coef_wr_ok && bus.coef_sel_gain)
        gain_reg <= bus.coef_wdata;
      if (state_reg == ADCC_S_CONV && mod_valid)
      begin
        data_reg   <= scale(mod_result, offset_reg, gain_reg);
        status_reg <= {4'h0, mod_channel};
      end
    end
  end

  // Gain = 2^22 * 2^23 / (raw - offset); the divider is a limitation worth sharing if area matters
  function automatic logic [23:0] gain_from(input logic [23:0] raw, input logic [23:0] off);
    logic [24:0] span;
    logic [47:0] q;
    span = (raw > off) ? 25'(raw) - 25'(off) : 25'h0000001;
    q    = 48'h200000000000 / 48'(span);
    gain_from = (q > 48'h0000FFFFFF) ? 24'hFFFFFF : q[23:0];
  endfunction
endmodule // adcc_device

// ==== rtl/adcc_host.sv ====
// Host end: drives mode and configuration, runs calibrations, checks parity
`timescale 1ns/1ps
module adcc_host
  import adcc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  adcc_if.host             bus,
  input  wire logic [2:0]  usr_mode,
  input  wire logic        usr_mode_wr,
  input  wire logic [9:0]  usr_rate,
  input  wire logic        usr_filter_type_select_bit,
  input  wire logic        usr_chop,
  input  wire logic        usr_zero_latency,
  input  wire logic        usr_parity,
  input  wire logic        usr_temp,
  input  wire logic        usr_gain_gt1,
  input  wire logic        usr_cs_n,
  input  wire logic        usr_coef_wr,
  input  wire logic        usr_coef_sel_gain,
  input  wire logic [23:0] usr_coef_wdata,
  input  wire logic        usr_read,
  output logic             usr_refused,
  output logic             usr_rd_valid,
  output logic [23:0]      usr_rd_data,
  output logic [3:0]       usr_rd_channel,
  output logic             usr_parity_err
);
  logic        zero_done_reg;
  logic        rd_valid_reg;
  logic [23:0] rd_data_reg;
  logic [3:0]  rd_chan_reg;
  logic        perr_reg;
  logic        refused_reg;
  logic [9:0]  rate_reg;

  wire rate_ok   = usr_rate != 10'h000;
  wire full_req  = usr_mode == MODE_INT_FULL || usr_mode == MODE_SYS_FULL;
  wire bad_full  = (usr_mode == MODE_INT_FULL && rate_reg[3:0] != 4'h0)
                   || (full_req && !zero_done_reg);
  wire mode_go   = usr_mode_wr && !bad_full;
  wire recv_odd  = ^{bus.data_word, bus.status_byte[STAT_PARITY_POS]};

  assign bus.op_mode                = usr_mode;
  assign bus.op_mode_wr             = mode_go;
  assign bus.filter_rate_word       = rate_reg;
  assign bus.filter_type_select_bit = usr_filter_type_select_bit;
  assign bus.chop_enable            = usr_chop;
  assign bus.zero_latency           = usr_zero_latency;
  assign bus.parity_enable_bit      = usr_parity;
  assign bus.status_append_bit      = usr_parity;
  assign bus.temp_sensor_select_bit = usr_temp;
  assign bus.gain_gt1               = usr_gain_gt1;
  assign bus.cs_n                   = usr_cs_n;
  assign bus.coef_wr                = usr_coef_wr;
  assign bus.coef_sel_gain          = usr_coef_sel_gain;
  assign bus.coef_wdata             = usr_coef_wdata;
  assign bus.data_rd                = usr_read && !bus.rdy_n;
  assign usr_refused                = refused_reg;
  assign usr_rd_valid               = rd_valid_reg;
  assign usr_rd_data                = rd_data_reg;
  assign usr_rd_channel             = rd_chan_reg;
  assign usr_parity_err             = perr_reg;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      zero_done_reg <= 1'b0;
      rd_valid_reg  <= 1'b0;
      rd_data_reg   <= 24'h000000;
      rd_chan_reg   <= 4'h0;
      perr_reg      <= 1'b0;
      refused_reg   <= 1'b0;
      rate_reg      <= FS_RST;
    end
    else
    begin
      refused_reg  <= usr_mode_wr && bad_full;
      rd_valid_reg <= bus.data_rd;
      if (rate_ok)
        rate_reg <= usr_rate;
      if (mode_go && (usr_mode == MODE_INT_ZERO || usr_mode == MODE_SYS_ZERO))
        zero_done_reg <= 1'b1;
      if (bus.data_rd)
      begin
        rd_data_reg <= bus.data_word;
        rd_chan_reg <= bus.status_byte[3:0];
        perr_reg    <= usr_parity && recv_odd;
      end
    end
  end
endmodule // adcc_host

// ==== dv/adcc_checker.sv ====
// Checker: timing and value relations on the host to device link
`timescale 1ns/1ps
module adcc_checker (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic [2:0]  op_mode,
  input wire logic        op_mode_wr,
  input wire logic        cs_n,
  input wire logic        coef_wr,
  input wire logic        coef_sel_gain,
  input wire logic        parity_enable_bit,
  input wire logic        status_append_bit,
  input wire logic        data_rd,
  input wire logic [23:0] offset_coef,
  input wire logic [23:0] gain_coef,
  input wire logic        dout_rdy,
  input wire logic        rdy_n,
  input wire logic [23:0] data_word,
  input wire logic [7:0]  status_byte
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Only a start from a settled state is judged; a start while busy is ignored
  sequence s_cal_req;
    op_mode_wr && op_mode[2] && !rdy_n;
  endsequence
  sequence s_ready_rise;
    $rose(rdy_n);
  endsequence
  property p_cal_start;
    s_cal_req |=> rdy_n;
  endproperty
  property p_rdy_cause;
    s_ready_rise |-> $past(op_mode_wr && op_mode[2]) || $past(data_rd);
  endproperty
  property p_dout_pin;
    dout_rdy == (cs_n ? 1'b1 : rdy_n);
  endproperty
  property p_stat_rdy;
    status_byte[7] == rdy_n;
  endproperty
  property p_parity_even;
    parity_enable_bit |-> (status_byte[4] == ^data_word);
  endproperty
  property p_parity_off;
    !parity_enable_bit |-> !status_byte[4];
  endproperty
  property p_append_par;
    parity_enable_bit |-> status_append_bit;
  endproperty
  property p_offset_src;
    $changed(offset_coef) |-> ($past(coef_wr) && !$past(coef_sel_gain)) || $fell(rdy_n);
  endproperty
  property p_gain_src;
    $changed(gain_coef) |-> ($past(coef_wr) && $past(coef_sel_gain)) || $fell(rdy_n);
  endproperty
  a_cal_start:    assert property (p_cal_start) else $error("ready not raised at start");
  a_rdy_cause:    assert property (p_rdy_cause) else $error("ready rose without cause");
  a_dout_pin:     assert property (p_dout_pin) else $error("data out pin wrong");
  a_stat_rdy:     assert property (p_stat_rdy) else $error("status ready bit wrong");
  a_parity_even:  assert property (p_parity_even) else $error("parity not even");
  a_parity_off:   assert property (p_parity_off) else $error("parity set while off");
  a_offset_src:   assert property (p_offset_src) else $error("offset changed unasked");
  a_gain_src:     assert property (p_gain_src) else $error("gain changed unasked");
  a_append_par:   assert property (p_append_par) else $error("status not appended");
endmodule // adcc_checker

// ==== dv/adcc_calibration_parity_control_tb.sv ====
// Testbench: both ends joined; calibrations, coefficient locks, parity reads
`timescale 1ns/1ps
module adcc_calibration_parity_control_tb;
  import adcc_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic [2:0]  usr_mode = MODE_CONT;
  logic        usr_mode_wr = 1'b0;
  logic [9:0]  usr_rate = 10'h001;
  logic        usr_filter_type_select_bit = 1'b0;
  logic        usr_chop = 1'b0;
  logic        usr_zl = 1'b0;
  logic        usr_par = 1'b0;
  logic        usr_temp = 1'b0;
  logic        usr_gain_gt1 = 1'b0;
  logic        usr_cs_n = 1'b0;
  logic        usr_coef_wr = 1'b0;
  logic        usr_coef_sel_gain = 1'b0;
  logic [23:0] usr_coef_wdata = 24'h000000;
  logic        usr_read = 1'b0;
  logic        mod_valid = 1'b0;
  logic [23:0] mod_result = 24'h000000;
  logic [3:0]  mod_channel = 4'h0;
  logic [23:0] exp_off = OFFSET_RST;
  logic        usr_refused, usr_rd_valid, usr_parity_err, temp_route, int_zero_connect;
  logic        int_full_connect, filter_filter_type_select_bit, filter_chop, filter_zero_latency, ref_seen;
  logic [23:0] usr_rd_data, raw;
  logic [3:0]  usr_rd_channel;
  logic [2:0]  mode_state;
  int          errors = 0;
  int          checks = 0;
  int          n;
  always #10 clk_sys = ~clk_sys;
  adcc_if i_adcc_if ();
  adcc_device i_adcc_device (.clk_sys(clk_sys), .rstn(rstn), .bus(i_adcc_if),
    .mod_valid(mod_valid), .mod_result(mod_result), .mod_channel(mod_channel),
    .temp_route(temp_route), .int_zero_connect(int_zero_connect),
    .int_full_connect(int_full_connect), .filter_filter_type_select_bit(filter_filter_type_select_bit),
    .filter_chop(filter_chop), .filter_zero_latency(filter_zero_latency),
    .mode_state(mode_state));
  adcc_host i_adcc_host (.clk_sys(clk_sys), .rstn(rstn), .bus(i_adcc_if),
    .usr_mode(usr_mode), .usr_mode_wr(usr_mode_wr), .usr_rate(usr_rate),
    .usr_filter_type_select_bit(usr_filter_type_select_bit), .usr_chop(usr_chop), .usr_zero_latency(usr_zl),
    .usr_parity(usr_par), .usr_temp(usr_temp), .usr_gain_gt1(usr_gain_gt1), .usr_cs_n(usr_cs_n),
    .usr_coef_wr(usr_coef_wr), .usr_coef_sel_gain(usr_coef_sel_gain),
    .usr_coef_wdata(usr_coef_wdata), .usr_read(usr_read), .usr_refused(usr_refused),
    .usr_rd_valid(usr_rd_valid), .usr_rd_data(usr_rd_data),
    .usr_rd_channel(usr_rd_channel), .usr_parity_err(usr_parity_err));
  adcc_checker i_adcc_checker (.clk_sys(clk_sys), .rstn(rstn), .op_mode(i_adcc_if.op_mode),
    .op_mode_wr(i_adcc_if.op_mode_wr), .cs_n(i_adcc_if.cs_n), .coef_wr(i_adcc_if.coef_wr),
    .coef_sel_gain(i_adcc_if.coef_sel_gain), .parity_enable_bit(i_adcc_if.parity_enable_bit),
    .data_rd(i_adcc_if.data_rd), .offset_coef(i_adcc_if.offset_coef),
    .status_append_bit(i_adcc_if.status_append_bit),
    .gain_coef(i_adcc_if.gain_coef), .dout_rdy(i_adcc_if.dout_rdy), .rdy_n(i_adcc_if.rdy_n),
    .data_word(i_adcc_if.data_word), .status_byte(i_adcc_if.status_byte));
  function automatic logic exp_par(input logic en, input logic [23:0] d);
    return en ? ^d : 1'b0;
  endfunction
  // Gain that stretches the calibrated span to half the code range, unity at 2^22
  function automatic logic [23:0] exp_gain(input logic [23:0] lvl, input logic [23:0] off);
    longint span;
    longint q;
    span = (lvl > off) ? longint'(lvl) - longint'(off) : 64'sh1;
    q = (64'sh1 <<< (GAIN_FRAC + DATA_W - 1)) / span;
    return (q > 64'sh0000000000FFFFFF) ? 24'hFFFFFF : 24'(q);
  endfunction
  task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Refusal is a one-cycle pulse, so it is gathered over a few cycles
  task automatic mode_wr(input logic [2:0] m);
    @(negedge clk_sys);
    usr_mode = m;
    usr_mode_wr = 1'b1;
    ref_seen = 1'b0;
    @(negedge clk_sys);
    usr_mode_wr = 1'b0;
    repeat (3)
    begin
      ref_seen = ref_seen | usr_refused;
      @(negedge clk_sys);
    end
  endtask
  task automatic coef_wr(input logic g, input logic [23:0] w);
    @(negedge clk_sys);
    usr_coef_wr = 1'b1;
    usr_coef_sel_gain = g;
    usr_coef_wdata = w;
    @(negedge clk_sys);
    usr_coef_wr = 1'b0;
    @(negedge clk_sys);
  endtask
  // Length is counted from the start request; two cycles of slack either way
  task automatic run_cal(input logic [2:0] m, input int len);
    logic [23:0] v;
    logic [23:0] e;
    v = 24'($urandom);
    mod_result = v;
    mod_valid = 1'b1;
    mode_wr(m);
    check("cal_rdy", i_adcc_if.rdy_n, 1);
    check("int_zero_conn", int_zero_connect, m == MODE_INT_ZERO);
    check("int_full_conn", int_full_connect, m == MODE_INT_FULL);
    n = 4;
    while (i_adcc_if.rdy_n !== 1'b0 && n < 70000)
    begin
      @(negedge clk_sys);
      n++;
    end
    mod_valid = 1'b0;
    check("cal_len", (n >= len - 2) && (n <= len + 2), 1);
    check("mode_idle", mode_state, MODE_IDLE);
    e = m[0] ? exp_gain(v, exp_off) : v;
    check("coef", m[0] ? i_adcc_if.gain_coef : i_adcc_if.offset_coef, e);
    exp_off = m[0] ? exp_off : v;
  endtask
  initial
  begin
    repeat (90000) @(posedge clk_sys);
    errors++;
    complete_run();
  end
  initial
  begin
    raw = 24'($urandom(84));
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    rstn = 1'b1;
    check("filter_type_select_bit_rst", filter_filter_type_select_bit, 0);
    check("chop_rst", filter_chop, 0);
    check("offset_rst", i_adcc_if.offset_coef, OFFSET_RST);
    check("gain_rst", i_adcc_if.gain_coef, GAIN_RST);
    mode_wr(MODE_SYS_FULL);
    check("refuse_order", ref_seen, 1);
    coef_wr(1'b0, 24'h123456);
    check("coef_lock", i_adcc_if.offset_coef, OFFSET_RST);
    run_cal(MODE_INT_ZERO, 4096);
    usr_filter_type_select_bit = 1'b1;
    run_cal(MODE_SYS_ZERO, 3072);
    check("filter_type_select_bit_sel", filter_filter_type_select_bit, 1);
    mode_wr(MODE_INT_FULL);
    check("refuse_rate", ref_seen, 1);
    usr_filter_type_select_bit = 1'b0;
    usr_chop = 1'b1;
    run_cal(MODE_INT_ZERO, 2048);
    check("chop_sel", filter_chop, 1);
    run_cal(MODE_SYS_FULL, 2048);
    usr_rate = 10'h010;
    run_cal(MODE_INT_FULL, 32768);
    usr_chop = 1'b0;
    usr_rate = 10'h001;
    // Midscale offset and unity gain make the scaled result equal the raw code
    coef_wr(1'b0, OFFSET_RST);
    coef_wr(1'b1, GAIN_RST);
    check("coef_idle_wr", i_adcc_if.offset_coef, OFFSET_RST);
    check("gain_idle_wr", i_adcc_if.gain_coef, GAIN_RST);
    mode_wr(MODE_CONT);
    for (int i = 0; i < 12; i++)
    begin
      raw = (i == 0) ? 24'hFFFFFE : 24'($urandom);
      @(negedge clk_sys);
      mod_result = raw;
      mod_channel = 4'($urandom);
      usr_par = (i < 2) ? 1'b1 : 1'($urandom);
      usr_temp = 1'($urandom);
      usr_cs_n = 1'($urandom);
      usr_zl = 1'($urandom);
      mod_valid = 1'b1;
      @(negedge clk_sys);
      mod_valid = 1'b0;
      @(negedge clk_sys);
      check("data_word", i_adcc_if.data_word, raw);
      check("stat_chan", i_adcc_if.status_byte[3:0], mod_channel);
      check("stat_par", i_adcc_if.status_byte[4], exp_par(usr_par, raw));
      check("temp_route", temp_route, usr_temp);
      check("zero_lat", filter_zero_latency, usr_zl);
      check("append", i_adcc_if.status_append_bit, usr_par);
      usr_read = 1'b1;
      @(negedge clk_sys);
      usr_read = 1'b0;
      n = 0;
      while (usr_rd_valid !== 1'b1 && n < 8)
      begin
        @(negedge clk_sys);
        n++;
      end
      check("rd_data", usr_rd_data, raw);
      check("rd_chan", usr_rd_channel, mod_channel);
      check("par_err", usr_parity_err, 0);
    end
    // A zero rate word is refused, so the last legal word stays
    usr_rate = 10'h000;
    @(negedge clk_sys);
    check("rate_hold", i_adcc_if.filter_rate_word, 10'h001);
    mode_wr(MODE_PWRDN);
    coef_wr(1'b0, 24'h000001);
    check("coef_pdn_wr", i_adcc_if.offset_coef, 24'h000001);
    // Gain above one doubles an internal full-scale run; a reset then abandons it
    usr_gain_gt1 = 1'b1;
    usr_chop = 1'b1;
    usr_rate = 10'h010;
    mode_wr(MODE_INT_FULL);
    repeat (32768) @(negedge clk_sys);
    check("cal_len_gain", i_adcc_if.rdy_n, 1);
    check("full_conn", int_full_connect, 1);
    rstn = 1'b0;
    repeat (8) @(negedge clk_sys);
    rstn = 1'b1;
    check("mode_rst", mode_state, MODE_CONT);
    check("offset_rst2", i_adcc_if.offset_coef, OFFSET_RST);
    check("chop_rst2", filter_chop, 0);
    complete_run();
  end
endmodule // adcc_calibration_parity_control_tb
